/* inc/lock_pkg.sv */
package lock_pkg;
  localparam logic [7:0] OP_READ_PROTECT = 8'h32;
  localparam logic [7:0] OP_READ_LOCK    = 8'h35;
  localparam logic [7:0] OP_SEQ_1        = 8'h3d;
  localparam logic [7:0] OP_SEQ_2        = 8'h2a;
  localparam logic [7:0] OP_SEQ_3        = 8'h7f;
  localparam logic [7:0] OP_SEQ_LOCK     = 8'h30;
  localparam logic [7:0] BYTE_SET        = 8'hff;
  localparam logic [7:0] BYTE_CLEAR      = 8'h00;
  localparam logic [7:0] S0_HI_MASK      = 8'hc0;
  localparam logic [7:0] S0_LO_MASK      = 8'h30;
  localparam int         NUM_SECTORS     = 8;
  localparam logic [5:0] DUMMY_END       = 6'd32;
  localparam logic [5:0] ADDR_END        = 6'd56;
  localparam logic [6:0] MAP_BITS        = 7'd64;
  localparam logic [63:0] PROTECT_RESET  = 64'h0;
  localparam logic [63:0] LOCK_RESET     = 64'h0;
  localparam int         PROGRAM_TIME_US = 3000;
  localparam int         CLK_MHZ         = 25;
  localparam int         PROGRAM_CYCLES  = PROGRAM_TIME_US * CLK_MHZ;
  localparam int         SECTOR_SHIFT    = 16;
  localparam int         PAGE_SHIFT      = 8;
  localparam logic [10:0] S0_LO_PAGES    = 11'd8;

  typedef enum logic [2:0] {
    st_cmd    = 3'b000,
    st_dummy  = 3'b001,
    st_out    = 3'b011,
    st_seq    = 3'b010,
    st_addr   = 3'b110,
    st_done   = 3'b111,
    st_ignore = 3'b101
  } cmd_state_e;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } spi_in_s;
endpackage : lock_pkg

/* src/sector_protect_lock_access.sv */
`timescale 1ns/1ps
// How it works
// - Protection bytes out, sector 0 first.
// - After eight bytes output is driven low.
// - Chip select release ends read, output off.
// - Locked sectors refuse program and erase until sys_rst.
// - Chip select rise starts timed lockdown.
// - Busy shown for whole lockdown time.
// - Lock bytes FFH locked, 00H unlocked, for sectors 1 to 7.
// - Sector 0 byte split into two fields.
// - Lock bytes out, sector 0 first.
// - After eight lock bytes output driven low.
// - Chip select release ends lock read.
// - Protection bytes FFH protected, 00H not.
module sector_protect_lock_access
  import lock_pkg::*;
#(
  parameter int PROGRAM_COUNT = PROGRAM_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic [63:0] protect_load,
  input  wire logic        protect_load_en,
  input  wire logic [18:0] op_addr,
  input  wire logic        op_req,
  output logic             so,
  output logic             so_oe,
  output logic             busy,
  output logic             op_refused,
  output logic [63:0]      sector_protect_map,
  output logic [63:0]      sector_lock_map
);
  spi_in_s     pin, prev;
  cmd_state_e  state, next_state;
  logic [5:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  shreg, next_shreg;
  logic [23:0] addr, next_addr;
  logic        sel_lock, next_sel_lock;
  logic [6:0]  out_idx, next_out_idx;
  logic [31:0] timer, next_timer;
  logic [18:0] pend_addr, next_pend_addr;
  logic        next_so, next_so_oe, next_busy, next_refused;
  logic [63:0] next_protect, next_lock;
  logic        rise, fall, cs_rise, cs_fall;
  logic [7:0]  rx_byte;

  function automatic logic is_locked(input logic [63:0] m, input logic [18:0] a);
    logic [2:0] s;
    s = a[18:SECTOR_SHIFT];
    if (s == 3'd0) begin
      if (a[18:PAGE_SHIFT] < S0_LO_PAGES) begin
        return m[7:6] == 2'b11;
      end
      return m[5:4] == 2'b11;
    end
    return m[s*8 +: 8] == BYTE_SET;
  endfunction : is_locked

  assign pin     = '{cs_n: cs_n, sck: sck, si: si};
  assign rise    = !pin.cs_n && pin.sck && !prev.sck;
  assign fall    = !pin.cs_n && !pin.sck && prev.sck;
  assign cs_rise = pin.cs_n && !prev.cs_n;
  assign cs_fall = !pin.cs_n && prev.cs_n;
  assign rx_byte = {shreg[6:0], pin.si};

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_addr      = addr;
    next_sel_lock  = sel_lock;
    next_out_idx   = out_idx;
    next_timer     = timer;
    next_pend_addr = pend_addr;
    next_so        = so;
    next_so_oe     = so_oe;
    next_busy      = busy;
    next_refused   = 1'b0;
    next_protect   = sector_protect_map;
    next_lock      = sector_lock_map;
    if (protect_load_en && !busy) begin
      next_protect = protect_load;
    end
    if (op_req) begin
      next_refused = is_locked(sector_lock_map, op_addr);
    end
    if (busy) begin
      next_timer = timer - 32'd1;
      if (timer == 32'd1) begin
        next_busy = 1'b0;
        if (pend_addr[18:SECTOR_SHIFT] != 3'd0) begin
          next_lock[pend_addr[18:SECTOR_SHIFT]*8 +: 8] = BYTE_SET;
        end else if (pend_addr[18:PAGE_SHIFT] < S0_LO_PAGES) begin
          next_lock[7:0] = sector_lock_map[7:0] | S0_HI_MASK;
        end else begin
          next_lock[7:0] = sector_lock_map[7:0] | S0_LO_MASK;
        end
      end
    end
    if (cs_fall) begin
      next_state   = st_cmd;
      next_bit_cnt = 6'd0;
    end
    if (cs_rise) begin
      next_so_oe = 1'b0;
      next_state = st_cmd;
      if (state == st_done && !busy) begin
        next_busy      = 1'b1;
        next_timer     = 32'(PROGRAM_COUNT);
        next_pend_addr = addr[18:0];
      end
    end
    if (rise) begin
      next_shreg   = rx_byte;
      next_bit_cnt = bit_cnt + 6'd1;
      unique case (state)
        st_cmd: begin
          if (bit_cnt[2:0] == 3'd7) begin
            if (rx_byte == OP_READ_PROTECT || rx_byte == OP_READ_LOCK) begin
              next_state    = st_dummy;
              next_sel_lock = rx_byte == OP_READ_LOCK;
            end else if (rx_byte == OP_SEQ_1) begin
              next_state = st_seq;
            end else begin
              next_state = st_ignore;
            end
          end
        end
        st_dummy: begin
          if (bit_cnt == DUMMY_END - 6'd1) begin
            next_state   = st_out;
            next_out_idx = 7'd0;
          end
        end
        st_seq: begin
          if (bit_cnt[2:0] == 3'd7) begin
            if ((bit_cnt[4:3] == 2'd1 && rx_byte != OP_SEQ_2) ||
                (bit_cnt[4:3] == 2'd2 && rx_byte != OP_SEQ_3) ||
                (bit_cnt[4:3] == 2'd3 && rx_byte != OP_SEQ_LOCK)) begin
              next_state = st_ignore;
            end else if (bit_cnt[4:3] == 2'd3) begin
              next_state = st_addr;
            end
          end
        end
        st_addr: begin
          next_addr = {addr[22:0], pin.si};
          if (bit_cnt == ADDR_END - 6'd1) begin
            next_state = st_done;
          end
        end
        st_out, st_done, st_ignore: begin
        end
      endcase
    end
    if (fall && state == st_out) begin
      next_so_oe = 1'b1;
      if (out_idx < MAP_BITS) begin
        next_so      = sel_lock ? sector_lock_map[{out_idx[5:3], ~out_idx[2:0]}]
                                : sector_protect_map[{out_idx[5:3], ~out_idx[2:0]}];
        next_out_idx = out_idx + 7'd1;
      end else begin
        next_so = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev               <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      state              <= st_cmd;
      bit_cnt            <= 6'd0;
      shreg              <= 8'h00;
      addr               <= 24'h000000;
      sel_lock           <= 1'b0;
      out_idx            <= 7'd0;
      timer              <= 32'h00000000;
      pend_addr          <= 19'h00000;
      so                 <= 1'b0;
      so_oe              <= 1'b0;
      busy               <= 1'b0;
      op_refused         <= 1'b0;
      sector_protect_map <= PROTECT_RESET;
      sector_lock_map    <= LOCK_RESET;
    end else begin
      prev               <= pin;
      state              <= next_state;
      bit_cnt            <= next_bit_cnt;
      shreg              <= next_shreg;
      addr               <= next_addr;
      sel_lock           <= next_sel_lock;
      out_idx            <= next_out_idx;
      timer              <= next_timer;
      pend_addr          <= next_pend_addr;
      so                 <= next_so;
      so_oe              <= next_so_oe;
      busy               <= next_busy;
      op_refused         <= next_refused;
      sector_protect_map <= next_protect;
      sector_lock_map    <= next_lock;
    end
  end

  // Outside sys_rst, lock bits can only ever be set, never cleared.
  a_lock_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(sector_lock_map) & ~sector_lock_map) == 64'h0)
    else $error("lock bit cleared");
  a_release_hiz: assert property (@(posedge clk) disable iff (sys_rst)
    cs_rise |=> !so_oe)
    else $error("output enabled after release");
  a_start_busy: assert property (@(posedge clk) disable iff (sys_rst)
    (cs_rise && state == st_done && !busy) |=> busy)
    else $error("lockdown did not start");
  a_short_ignore: assert property (@(posedge clk) disable iff (sys_rst)
    (cs_rise && state == st_addr && !busy) |=> !busy)
    else $error("short lockdown started");
  a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  a_refuse_lock: assert property (@(posedge clk) disable iff (sys_rst)
    (op_req && is_locked(sector_lock_map, op_addr)) |=> op_refused)
    else $error("locked op not refused");
  a_s0_field: assert property (@(posedge clk) disable iff (sys_rst)
    sector_lock_map[3:0] == 4'h0)
    else $error("sector 0 low bits set");
  a_out_first: assert property (@(posedge clk) disable iff (sys_rst)
    (fall && state == st_out && out_idx == 7'd0 && !sel_lock)
    |=> so == sector_protect_map[7])
    else $error("first bit wrong");
endmodule : sector_protect_lock_access

/* verification/spi_host.sv */
`timescale 1ns/1ps
module spi_host (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      si = d[i];
      tick(4);
      // A released line has no pull; show the wrong level so a late enable is caught.
      r[i] = so_oe ? so : ~so;
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
  endtask : xfer
  task automatic frame_start();
    tick(1);
    cs_n = 1'b0;
    tick(2);
  endtask : frame_start
  task automatic frame_end();
    tick(4);
    cs_n = 1'b1;
    si   = ~si;
  endtask : frame_end
endmodule : spi_host

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench
  import lock_pkg::*;
;
  localparam int          PCNT = 20;
  localparam logic [63:0] PMAP = 64'h00ff_00ff_ff00_ff30;
  logic        clk;
  logic        sys_rst;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic [63:0] protect_load;
  logic        protect_load_en;
  logic [18:0] op_addr;
  logic        op_req;
  logic        so;
  logic        so_oe;
  logic        busy;
  logic        op_refused;
  logic [63:0] sector_protect_map;
  logic [63:0] sector_lock_map;
  logic [63:0] m;
  logic [7:0]  seq [4] = '{OP_SEQ_1, OP_SEQ_2, OP_SEQ_3, OP_SEQ_LOCK};
  int          failures = 0;
  int          checks_done = 0;
  spi_host host (.clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
  sector_protect_lock_access #(.PROGRAM_COUNT(PCNT)) dut (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
    .protect_load(protect_load), .protect_load_en(protect_load_en),
    .op_addr(op_addr), .op_req(op_req), .so(so), .so_oe(so_oe), .busy(busy),
    .op_refused(op_refused), .sector_protect_map(sector_protect_map),
    .sector_lock_map(sector_lock_map)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic read_map(input logic [7:0] op, output logic [63:0] mp);
    logic [7:0] r;
    host.frame_start();
    host.xfer(op, r);
    repeat (3) host.xfer(8'ha5, r);
    for (int n = 0; n < NUM_SECTORS; n++) begin
      host.xfer(8'h5a, r);
      mp[8*n +: 8] = r;
    end
    check("so_oe_on", 64'h1, 64'(so_oe));
    host.xfer(8'h00, r);
    host.frame_end();
    host.tick(2);
    check("so_oe_off", 64'h0, 64'(so_oe));
  endtask : read_map
  task automatic lock(input logic [23:0] a, input int nb, input int exp);
    logic [7:0] r;
    int         n;
    host.frame_start();
    foreach (seq[i]) host.xfer(seq[i], r);
    for (int i = 0; i < nb; i++) host.xfer(a[23-8*i -: 8], r);
    host.frame_end();
    n = 0;
    for (int k = 0; k < 200; k++) begin
      host.tick(1);
      if (busy === 1'b1) n++;
      else if (n > 0 || k > 30) break;
      if (k == 199) begin
        failures++;
        $display("BAD busy_wait expected %0d seen timeout", exp);
        complete_run();
      end
    end
    check("busy_cycles", 64'(exp), 64'(n));
  endtask : lock
  task automatic probe(input logic [18:0] a, input logic e);
    op_addr = a;
    op_req  = 1'b1;
    host.tick(1);
    check("refused", 64'(e), 64'(op_refused));
    op_req = 1'b0;
    host.tick(2);
  endtask : probe
  initial begin
    sys_rst         = 1'b1;
    protect_load    = '0;
    protect_load_en = 1'b0;
    op_addr         = '0;
    op_req          = 1'b0;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("lock_rst", 64'h0, sector_lock_map);
    check("busy_rst", 64'h0, 64'(busy));
    protect_load    = PMAP;
    protect_load_en = 1'b1;
    host.tick(1);
    protect_load_en = 1'b0;
    check("protect_map", PMAP, sector_protect_map);
    read_map(OP_READ_PROTECT, m);
    check("protect_read", PMAP, m);
    probe(19'h30010, 1'b0);
    lock(24'h034567, 3, PCNT);
    lock(24'h000200, 3, PCNT);
    check("lock_s0a", 64'h0000_0000_ff00_00c0, sector_lock_map);
    lock(24'h000900, 3, PCNT);
    // Short address: two of three address bytes, nothing may change.
    lock(24'h050000, 2, 0);
    read_map(OP_READ_LOCK, m);
    check("lock_read", 64'h0000_0000_ff00_00f0, m);
    probe(19'h30010, 1'b1);
    probe(19'h50000, 1'b0);
    probe(19'h00100, 1'b1);
    probe(19'h00900, 1'b1);
    complete_run();
  end
endmodule : testbench
